// *** logic/touch_pkg.sv ***
package touch_pkg;
  // Number of electrodes and data widths.
  localparam int NUM_ELECTRODES = 3;
  localparam int SAMPLE_W       = 10;
  localparam int LEVEL_W        = 8;
  localparam int SLOTS          = 6;
  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_TOUCH_TRIP_E0   = 8'h29;
  localparam logic [7:0] IDX_RELEASE_TRIP_E0 = 8'h2a;
  localparam logic [7:0] IDX_TOUCH_TRIP_E1   = 8'h2b;
  localparam logic [7:0] IDX_RELEASE_TRIP_E1 = 8'h2c;
  localparam logic [7:0] IDX_TOUCH_TRIP_E2   = 8'h2d;
  localparam logic [7:0] IDX_RELEASE_TRIP_E2 = 8'h2e;
  localparam logic [7:0] IDX_TOUCH_STATUS    = 8'h00;
  localparam logic [7:0] IDX_EVENT_STATUS    = 8'h30;
  localparam logic [7:0] IDX_EVENT_MASK      = 8'h31;
  localparam logic [7:0] IDX_FIRST_TRIP      = 8'h29;
  // Reset values.
  localparam logic [7:0] TRIP_RESET = 8'h00;
  localparam logic [5:0] MASK_RESET = 6'h3f;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** logic/trip_level_mem.sv ***
`timescale 1ns/1ps
// Holds the six trip levels, written and read by the bus slave.
module trip_level_mem #(
  parameter int DEPTH = 6,
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // Write port.
  input  wire logic                     wr_en,
  input  wire logic [2:0]               wr_idx,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Registered read port.
  input  wire logic [2:0]               rd_idx,
  output logic      [WIDTH-1:0]         rd_data,
  // All levels, flat, for the detectors.
  output logic      [DEPTH*WIDTH-1:0]   levels
);
  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [WIDTH-1:0] rd_r;
  logic [WIDTH-1:0] rd_nxt;

  // Next entry values; the chosen slot takes the written byte.
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = (wr_en && wr_idx == i[2:0]) ? wr_data : mem_r[i];
    end
    rd_nxt = (int'(rd_idx) < DEPTH) ? mem_r[rd_idx] : '0;
  end

  // Registers the entries and the read data.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= touch_pkg::TRIP_RESET;
      end
      rd_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      rd_r  <= rd_nxt;
    end
  end

  // Presents every entry to the detection logic.
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_flat
      assign levels[g*WIDTH +: WIDTH] = mem_r[g];
    end
  endgenerate
  assign rd_data = rd_r;
endmodule // trip_level_mem

// *** logic/touch_threshold_detect.sv ***
`timescale 1ns/1ps
// Contract
// - Delta is baseline minus filtered sample, since a press lowers the count.
// - Touch is declared when the filtered-to-baseline gap grows large enough.
// - While touched, the electrode's baseline hold output stays asserted.
// - A detected touch raises an interrupt toward the host.
// - A detected touch updates the electrode's bit in touch status.
// - Each electrode has its own touch and release trip levels.
// - The touch trip level is the delta that triggers a touch.
// - The release trip level is the delta that recognises a release.
// - A release updates status, raises an interrupt and releases the baseline.
// - Touch trip levels for electrodes zero to two, any value 0 to 255.
// - Release trip levels for electrodes zero to two, any value 0 to 255.
// - All touch trip levels zero disables detection; baseline just filters.
// - Baseline holds from touch until release of that touch.
module touch_threshold_detect #(
  parameter int N  = touch_pkg::NUM_ELECTRODES,
  parameter int SW = touch_pkg::SAMPLE_W
) (
  // Clock and reset.
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Filter samples, one word per electrode, with a strobe each.
  input  wire logic [N*SW-1:0]   filtered_data,
  input  wire logic [N*SW-1:0]   baseline_data,
  input  wire logic [N-1:0]      sample_valid,
  // Detection outputs.
  output logic      [N-1:0]      baseline_hold,
  output logic      [N-1:0]      touch_state,
  output logic                   irq,
  // AXI4-Lite write address.
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response.
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data.
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  localparam int LW = touch_pkg::LEVEL_W;

  typedef enum logic [1:0] {RD_IDLE, RD_MEM, RD_DONE} rd_state_t;

  // Trip level storage signals.
  logic [touch_pkg::SLOTS*LW-1:0] levels;
  logic [LW-1:0]    mem_rd_data;
  logic             mem_wr_en;
  logic [2:0]       mem_wr_idx;
  logic [2:0]       mem_rd_idx;

  // Write channel state.
  logic             aw_held_r, aw_held_nxt;
  logic [7:0]       aw_addr_r, aw_addr_nxt;
  logic             w_held_r, w_held_nxt;
  logic [31:0]      w_data_r, w_data_nxt;
  logic [3:0]       w_strb_r, w_strb_nxt;
  logic             bvalid_r, bvalid_nxt;
  logic [1:0]       bresp_r, bresp_nxt;

  // Read channel state.
  rd_state_t        rd_state_r, rd_state_nxt;
  logic [7:0]       ar_addr_r, ar_addr_nxt;
  logic [31:0]      rdata_r, rdata_nxt;
  logic [1:0]       rresp_r, rresp_nxt;

  // Detection and interrupt state.
  logic [N-1:0]     touch_r, touch_nxt;
  logic [2*N-1:0]   event_r, event_nxt;
  logic [2*N-1:0]   mask_r, mask_nxt;
  logic [N-1:0]     set_touch;
  logic [N-1:0]     set_release;
  logic             detect_enable;

  // Helper decode signals.
  logic             wr_fire;
  logic [7:0]       wr_addr;
  logic [7:0]       trip_off;
  logic             wr_is_trip;
  logic             rd_take;
  logic [7:0]       rd_off;

  trip_level_mem #(
    .DEPTH (touch_pkg::SLOTS),
    .WIDTH (LW)
  ) u_levels (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_en   (mem_wr_en),
    .wr_idx  (mem_wr_idx),
    .wr_data (w_data_r[LW-1:0]),
    .rd_idx  (mem_rd_idx),
    .rd_data (mem_rd_data),
    .levels  (levels)
  );

  // Detection stays off while every touch trip level is zero.
  always_comb begin
    detect_enable = 1'b0;
    for (int e = 0; e < N; e++) begin
      detect_enable = detect_enable | (|levels[(2*e)*LW +: LW]);
    end
  end

  // Per electrode comparison with hysteresis.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_det
      logic [SW:0]   delta;
      logic [LW-1:0] touch_lvl;
      logic [LW-1:0] release_lvl;
      logic          neg;
      assign touch_lvl   = levels[(2*g)*LW +: LW];
      assign release_lvl = levels[(2*g+1)*LW +: LW];
      // Baseline minus filtered; a press drives the filtered count down.
      assign delta = {1'b0, baseline_data[g*SW +: SW]}
                   - {1'b0, filtered_data[g*SW +: SW]};
      assign neg = delta[SW];
      assign set_touch[g] = sample_valid[g] && detect_enable && !touch_r[g] && !neg
                         && (delta[SW-1:0] >= SW'(touch_lvl));
      assign set_release[g] = sample_valid[g] && touch_r[g]
                           && (neg || delta[SW-1:0] <= SW'(release_lvl)
                               || !detect_enable);
    end
  endgenerate

  // Touch state, event flags and mask next values.
  always_comb begin
    touch_nxt = (touch_r | set_touch) & ~set_release;
    event_nxt = event_r;
    mask_nxt  = mask_r;
    if (rd_take && rd_off == touch_pkg::IDX_EVENT_STATUS) begin
      event_nxt = '0;
    end
    // New events win over the clearing read.
    event_nxt = event_nxt | {set_release, set_touch};
    if (mem_wr_en == 1'b0 && wr_fire && wr_addr == touch_pkg::IDX_EVENT_MASK
        && w_strb_r[0]) begin
      mask_nxt = w_data_r[2*N-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      touch_r <= '0;
      event_r <= '0;
      mask_r  <= touch_pkg::MASK_RESET;
    end else begin
      touch_r <= touch_nxt;
      event_r <= event_nxt;
      mask_r  <= mask_nxt;
    end
  end

  assign baseline_hold = touch_r;
  assign touch_state   = touch_r;
  assign irq           = |(event_r & mask_r);

  // Write path: address and data caught in either order, then applied.
  always_comb begin
    wr_addr    = {2'b00, aw_addr_r[7:2]};
    wr_fire    = aw_held_r && w_held_r && !bvalid_r;
    trip_off   = wr_addr - touch_pkg::IDX_FIRST_TRIP;
    wr_is_trip = (wr_addr >= touch_pkg::IDX_TOUCH_TRIP_E0)
              && (wr_addr <= touch_pkg::IDX_RELEASE_TRIP_E2);
    mem_wr_en  = wr_fire && wr_is_trip && w_strb_r[0];
    mem_wr_idx = trip_off[2:0];
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt  = w_held_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (wr_is_trip || wr_addr == touch_pkg::IDX_EVENT_MASK)
                  ? touch_pkg::RESP_OKAY : touch_pkg::RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r  <= 1'b0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= touch_pkg::RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r  <= w_held_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
    end
  end

  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // Read path: address taken, one cycle for the level store, then data.
  always_comb begin
    rd_take      = (rd_state_r == RD_IDLE) && s_axi_arvalid;
    rd_off       = {2'b00, s_axi_araddr[7:2]};
    rd_state_nxt = rd_state_r;
    ar_addr_nxt  = ar_addr_r;
    rdata_nxt    = rdata_r;
    rresp_nxt    = rresp_r;
    // The store's read register is loaded at the take edge, so it is ready in RD_MEM.
    mem_rd_idx   = 3'(rd_off - touch_pkg::IDX_FIRST_TRIP);
    case (rd_state_r)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          ar_addr_nxt  = rd_off;
          rd_state_nxt = RD_MEM;
          rresp_nxt    = touch_pkg::RESP_OKAY;
          rdata_nxt    = '0;
          if (rd_off == touch_pkg::IDX_TOUCH_STATUS) begin
            rdata_nxt = {{(32-N){1'b0}}, touch_r};
          end else if (rd_off == touch_pkg::IDX_EVENT_STATUS) begin
            rdata_nxt = {{(32-2*N){1'b0}}, event_r};
          end else if (rd_off == touch_pkg::IDX_EVENT_MASK) begin
            rdata_nxt = {{(32-2*N){1'b0}}, mask_r};
          end else if (rd_off < touch_pkg::IDX_TOUCH_TRIP_E0
                       || rd_off > touch_pkg::IDX_RELEASE_TRIP_E2) begin
            rresp_nxt = touch_pkg::RESP_SLVERR;
          end
        end
      end
      RD_MEM: begin
        rd_state_nxt = RD_DONE;
      end
      RD_DONE: begin
        if (s_axi_rready) begin
          rd_state_nxt = RD_IDLE;
        end
      end
      default: begin
        rd_state_nxt = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_state_r <= RD_IDLE;
      ar_addr_r  <= '0;
      rdata_r    <= '0;
      rresp_r    <= touch_pkg::RESP_OKAY;
    end else begin
      rd_state_r <= rd_state_nxt;
      ar_addr_r  <= ar_addr_nxt;
      rresp_r    <= rresp_nxt;
      // Trip levels come from the store's registered read port.
      if (rd_state_r == RD_MEM && ar_addr_r >= touch_pkg::IDX_TOUCH_TRIP_E0
          && ar_addr_r <= touch_pkg::IDX_RELEASE_TRIP_E2) begin
        rdata_r <= {24'h000000, mem_rd_data};
      end else begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign s_axi_arready = (rd_state_r == RD_IDLE);
  assign s_axi_rvalid  = (rd_state_r == RD_DONE);
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
endmodule // touch_threshold_detect

// *** bench/pad_source.sv ***
`timescale 1ns/1ps
// Stands in for the filter stages: a fixed baseline and a pressed sample.
module pad_source #(
  parameter logic [9:0] BASE = 10'h200
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Press depth per electrode, two's complement.
  input  wire logic [29:0] press,
  // Sample stream toward the detector.
  output logic      [29:0] filtered_data,
  output logic      [29:0] baseline_data,
  output logic      [2:0]  sample_valid
);
  logic [1:0] tick_r;
  // Strobe every fourth cycle, quiet in reset.
  always_ff @(posedge sys_clk) begin
    tick_r <= rst_n ? tick_r + 2'h1 : 2'h0;
  end
  assign sample_valid = {3{tick_r == 2'h3}};
  assign baseline_data = {3{BASE}};
  // A press lowers the count below the baseline.
  always_comb begin
    for (int e = 0; e < 3; e++) begin
      filtered_data[e*10 +: 10] = BASE - press[e*10 +: 10];
    end
  end
endmodule // pad_source

// *** bench/touch_threshold_detect_chk.sv ***
`timescale 1ns/1ps
// Watches the detector ports for timing and protocol slips.
module touch_threshold_chk (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Samples and detection.
  input wire logic [29:0] filtered_data,
  input wire logic [29:0] baseline_data,
  input wire logic [2:0]  sample_valid,
  input wire logic [2:0]  baseline_hold,
  input wire logic [2:0]  touch_state,
  input wire logic        irq,
  // Bus handshakes.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid
);
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  // Channel takes.
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_take;
    aw_hs && w_hs;
  endsequence
  sequence ar_take;
    ar_hs;
  endsequence
  a_hold_is_state: assert property (baseline_hold == touch_state)
    else $error("baseline hold differs from touch state");
  a_change_on_strobe: assert property (
    ((touch_state ^ $past(touch_state)) & ~$past(sample_valid)) == 3'h0)
    else $error("touch state moved without a sample strobe");
  a_negative_clear: assert property (
    sample_valid[0] && baseline_data[9:0] < filtered_data[9:0] |=> !touch_state[0])
    else $error("touch held with sample above baseline");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(ar_hs) ||
    $past(aw_hs, 2) || $past(w_hs, 2))
    else $error("interrupt dropped without a bus access");
  a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (ar_take |-> ##2 s_axi_rvalid)
    else $error("read response late");
  a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_unmapped_err: assert property (ar_hs && s_axi_araddr == 8'h04 |->
    ##2 s_axi_rvalid && s_axi_rresp == touch_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule // touch_threshold_chk
bind touch_threshold_detect touch_threshold_chk u_chk (.sys_clk, .rst_n, .filtered_data,
  .baseline_data, .sample_valid, .baseline_hold, .touch_state, .irq, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rresp, .s_axi_rvalid);

// *** bench/test_touch_threshold_detect.sv ***
`timescale 1ns/1ps
// Drives the detector from a host and a pad source and checks its answers.
module test_touch_threshold_detect;
  logic        sys_clk, rst_n, irq, st, n;
  logic [29:0] filtered_data, baseline_data, press;
  logic [2:0]  sample_valid, baseline_hold, touch_state;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, ev;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [9:0]  t, r, dv [6];
  int          err_count, num_checks, seed;
  touch_threshold_detect dut (.sys_clk, .rst_n, .filtered_data, .baseline_data,
    .sample_valid, .baseline_hold, .touch_state, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pad_source src (.sys_clk, .rst_n, .press, .filtered_data, .baseline_data, .sample_valid);
  // Free-running clock.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Prints the verdict and stops.
  task automatic test_done;
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic [7:0] a4(input logic [7:0] i);
    return {i[5:0], 2'h0};
  endfunction
  // Next touch state from press depth and both trip levels.
  function automatic logic nxt(input logic s, input logic [9:0] d, input logic [9:0] tl,
                               input logic [9:0] rl);
    if (d[9]) return 1'b0;
    return s ? (d > rl) : (d >= tl);
  endfunction
  // One write, address and data offered together, answer awaited.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw, v;
    int k;
    k = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a4(a);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ga = s_axi_awvalid && s_axi_awready;
      gw = s_axi_wvalid && s_axi_wready;
      v = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge sys_clk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
      if (v) s_axi_bready <= 1'b0;
      k++;
    end while (!v && k < 40);
    if (!v) begin
      err_count++;
      test_done;
    end
  endtask
  // One read, data and response taken with the answer.
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic g, v;
    int k;
    k = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      g = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge sys_clk);
      if (g) s_axi_arvalid <= 1'b0;
      if (v) s_axi_rready <= 1'b0;
      k++;
    end while (!v && k < 40);
    if (!v) begin
      err_count++;
      test_done;
    end
  endtask
  // Sets one pad and lets a few strobes pass.
  task automatic poke(input int e, input logic [9:0] v);
    press[e*10 +: 10] <= v;
    repeat (10) @(posedge sys_clk);
  endtask
  // Main sequence.
  initial begin
    seed = 92773;
    {err_count, num_checks, rst_n, press, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axr(a4(touch_pkg::IDX_FIRST_TRIP + 8'(i)), rd, rr);
      chk("trip reset", 32'(touch_pkg::TRIP_RESET), rd);
    end
    axr(a4(touch_pkg::IDX_EVENT_MASK), rd, rr);
    chk("mask reset", 32'(touch_pkg::MASK_RESET), rd);
    axr(8'h04, rd, rr);
    chk("unmapped resp", 32'(touch_pkg::RESP_SLVERR), 32'(rr));
    axw(8'h01, 32'h0);
    chk("unmapped bresp", 32'(touch_pkg::RESP_SLVERR), 32'(br));
    for (int i = 0; i < 6; i++) begin
      ev[7:0] = 8'($random(seed)) | 8'h01;
      axw(touch_pkg::IDX_FIRST_TRIP + 8'(i), {24'h0, ev[7:0]});
      chk("trip bresp", 32'(touch_pkg::RESP_OKAY), 32'(br));
      axr(a4(touch_pkg::IDX_FIRST_TRIP + 8'(i)), rd, rr);
      chk("trip readback", {24'h0, ev[7:0]}, rd);
    end
    // Electrodes one and two met a zero touch level at delta zero while electrode
    // zero enabled detection, so both touched and released before their levels came.
    axr(a4(touch_pkg::IDX_EVENT_STATUS), rd, rr);
    chk("early events", 32'h36, rd);
    for (int e = 0; e < 3; e++) begin
      t = 10'h002 + 10'($unsigned($random(seed)) % 200);
      r = 10'($unsigned($random(seed)) % (t - 10'h001));
      axw(touch_pkg::IDX_TOUCH_TRIP_E0 + 8'(2 * e), 32'(t));
      axw(touch_pkg::IDX_RELEASE_TRIP_E0 + 8'(2 * e), 32'(r));
      dv = '{t - 10'h001, t, r + 10'h001, r, t, 10'h3f0};
      st = 1'b0;
      for (int s = 0; s < 6; s++) begin
        n = nxt(st, dv[s], t, r);
        ev = (n != st) ? 32'h1 << (n ? e : e + 3) : 32'h0;
        st = n;
        poke(e, dv[s]);
        chk("touch", 32'(st), 32'(touch_state[e]));
        chk("hold", 32'(st), 32'(baseline_hold[e]));
        chk("irq", 32'(ev != 0), 32'(irq));
        axr(a4(touch_pkg::IDX_EVENT_STATUS), rd, rr);
        chk("event", ev, rd);
        axr(a4(touch_pkg::IDX_TOUCH_STATUS), rd, rr);
        chk("status", 32'(st) << e, rd);
      end
    end
    axw(touch_pkg::IDX_EVENT_MASK, 32'h0);
    poke(2, 10'h0ff);
    chk("masked irq", 32'h0, 32'(irq));
    axw(touch_pkg::IDX_EVENT_MASK, 32'h3f);
    chk("unmasked irq", 32'h1, 32'(irq));
    axr(a4(touch_pkg::IDX_EVENT_STATUS), rd, rr);
    chk("event", 32'h4, rd);
    chk("cleared irq", 32'h0, 32'(irq));
    poke(2, 10'h3f0);
    for (int i = 0; i < 3; i++) begin
      axw(touch_pkg::IDX_TOUCH_TRIP_E0 + 8'(2 * i), 32'h0);
    end
    poke(0, 10'h0ff);
    chk("disabled touch", 32'h0, 32'(touch_state));
    test_done;
  end
endmodule // test_touch_threshold_detect
